// ### src/flow_sensor_end.sv
// Sensor end: command decoding, sleep and wake, identity and checksums
`timescale 1ns/1ps
`default_nettype none
`include "sensor_consts.svh"
module flow_sensor_end
  import sensor_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h40,
  // Arbitrary value; low two digits 1x mark a finalized build
  parameter logic [31:0] PRODUCT_ID = 32'h0a0b0c12,
  // Decimal 2101000001: year 21, week 01, sequence 000001
  parameter logic [63:0] SERIAL_NO = 64'h000000007d3ab741,
  parameter int unsigned WAKE_CYC = `WAKE_CYC,
  parameter int unsigned STOP_CYC = `STOP_MAX_CYC
)
(
  input wire logic clk,
  input wire logic rst_n,
  sensor_link_if.dev link,
  input wire logic meas_start,
  input wire logic [15:0] flow_raw,
  input wire logic [15:0] temp_raw,
  output dev_mode_t mode,
  output logic soft_reset,
  output logic cmd_ignored
);
  logic [1:0] scl_s_q;
  logic [1:0] sda_s_q;
  logic scl_p_q;
  logic sda_p_q;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  slv_ph_t ph_q;
  slv_ph_t nxt_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic gc_q;
  logic [15:0] cmd_q;
  logic [1:0] cbyte_q;
  logic [7:0] rdb_q;
  logic [1:0] pos_q;
  logic [2:0] wsel_q;
  logic mack_q;
  logic sda_oe_q;
  logic exec_q;
  logic wake_q;
  dev_mode_t mode_q;
  logic [31:0] tmr_q;
  logic id_q;
  logic srst_q;
  logic ign_q;
  logic receptive;
  logic [15:0] word;
  logic [7:0] tx_byte;

  // Pins pass two flops; the first stage is read by the second only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      scl_s_q <= {scl_s_q[0], link.scl};
      sda_s_q <= {sda_s_q[0], link.sda};
      scl_p_q <= scl_s_q[1];
      sda_p_q <= sda_s_q[1];
    end
  end

  // Edge and framing events on the synchronised wires
  assign scl_rise = scl_s_q[1] & ~scl_p_q;
  assign scl_fall = ~scl_s_q[1] & scl_p_q;
  assign start_ev = scl_s_q[1] & scl_p_q & sda_p_q & ~sda_s_q[1];
  assign stop_ev = scl_s_q[1] & scl_p_q & ~sda_p_q & sda_s_q[1];
  // Stopping and waking phases answer no address at all
  assign receptive = (mode_q == M_IDLE) || (mode_q == M_MEAS);

  // Read word selection and its checksum byte
  always_comb
  begin
    word = 16'h0000;
    if (id_q)
    begin
      case (wsel_q)
        3'h0: word = PRODUCT_ID[31:16];
        3'h1: word = PRODUCT_ID[15:0];
        3'h2: word = SERIAL_NO[63:48];
        3'h3: word = SERIAL_NO[47:32];
        3'h4: word = SERIAL_NO[31:16];
        3'h5: word = SERIAL_NO[15:0];
        default: word = 16'h0000;
      endcase
    end
    else if (mode_q == M_MEAS)
    begin
      word = wsel_q[0] ? temp_raw : flow_raw;
    end
    case (pos_q)
      2'h0: tx_byte = word[15:8];
      2'h1: tx_byte = word[7:0];
      default: tx_byte = crc8(word);
    endcase
  end

  // Bus slave: address match, byte shifting, acknowledge and read-out
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ph_q <= P_OFF;
      nxt_q <= P_WR;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      gc_q <= 1'b0;
      cmd_q <= 16'h0000;
      cbyte_q <= 2'h0;
      rdb_q <= 8'h00;
      pos_q <= 2'h0;
      wsel_q <= 3'h0;
      mack_q <= 1'b0;
      sda_oe_q <= 1'b0;
      exec_q <= 1'b0;
      wake_q <= 1'b0;
    end
    else
    begin
      exec_q <= 1'b0;
      wake_q <= 1'b0;
      if (start_ev)
      begin
        ph_q <= P_ADDR;
        cnt_q <= 4'h0;
        cbyte_q <= 2'h0;
        sda_oe_q <= 1'b0;
      end
      else if (stop_ev)
      begin
        ph_q <= P_OFF;
        sda_oe_q <= 1'b0;
      end
      else if (scl_rise)
      begin
        case (ph_q)
          P_ADDR, P_WR:
          begin
            sh_q <= {sh_q[6:0], sda_s_q[1]};
            cnt_q <= cnt_q + 4'h1;
          end
          P_RD: cnt_q <= cnt_q + 4'h1;
          P_MACK: mack_q <= ~sda_s_q[1];
          default: ;
        endcase
      end
      else if (scl_fall)
      begin
        case (ph_q)
          P_ADDR:
          begin
            if (cnt_q == 4'h8)
            begin
              ph_q <= P_OFF;
              if (mode_q == M_SLEEP)
              begin
                // No acknowledge here; reset calls are not answered either
                wake_q <= (sh_q[7:1] == DEV_ADDR) & ~sh_q[0];
              end
              else if (receptive && sh_q[7:1] == DEV_ADDR)
              begin
                ph_q <= P_AACK;
                nxt_q <= sh_q[0] ? P_RD : P_WR;
                gc_q <= 1'b0;
                sda_oe_q <= 1'b1;
                pos_q <= 2'h0;
                wsel_q <= 3'h0;
              end
              else if (receptive && sh_q == `GC_ADDR)
              begin
                ph_q <= P_AACK;
                nxt_q <= P_WR;
                gc_q <= 1'b1;
                sda_oe_q <= 1'b1;
              end
            end
          end
          P_WR:
          begin
            if (cnt_q == 4'h8)
            begin
              ph_q <= P_AACK;
              nxt_q <= P_WR;
              sda_oe_q <= 1'b1;
              cmd_q <= {cmd_q[7:0], sh_q};
              // Only the code bytes start a command; arguments are ignored
              exec_q <= (gc_q && cbyte_q == 2'h0) || (!gc_q && cbyte_q == 2'h1);
              cbyte_q <= (cbyte_q == 2'h3) ? cbyte_q : cbyte_q + 2'h1;
            end
          end
          P_AACK:
          begin
            ph_q <= nxt_q;
            cnt_q <= 4'h0;
            sda_oe_q <= (nxt_q == P_RD) ? ~tx_byte[7] : 1'b0;
            rdb_q <= tx_byte;
          end
          P_RD:
          begin
            if (cnt_q == 4'h8)
            begin
              sda_oe_q <= 1'b0;
              ph_q <= P_MACK;
              if (pos_q == 2'h2)
              begin
                pos_q <= 2'h0;
                wsel_q <= (wsel_q == 3'h5) ? 3'h0 : wsel_q + 3'h1;
              end
              else
              begin
                pos_q <= pos_q + 2'h1;
              end
            end
            else
            begin
              sda_oe_q <= ~rdb_q[3'h7 - cnt_q[2:0]];
            end
          end
          P_MACK:
          begin
            // Master nack ends the read; wire left released
            if (mack_q)
            begin
              ph_q <= P_RD;
              cnt_q <= 4'h0;
              rdb_q <= tx_byte;
              sda_oe_q <= ~tx_byte[7];
            end
            else
            begin
              ph_q <= P_OFF;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Operating mode, timers and command effects
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_q <= M_IDLE;
      tmr_q <= 32'h0;
      id_q <= 1'b0;
      srst_q <= 1'b0;
      ign_q <= 1'b0;
    end
    else
    begin
      srst_q <= 1'b0;
      ign_q <= 1'b0;
      if (exec_q && gc_q && cmd_q[7:0] == `GC_RESET)
      begin
        mode_q <= M_IDLE;
        id_q <= 1'b0;
        srst_q <= 1'b1;
      end
      else
      begin
        case (mode_q)
          M_IDLE:
          begin
            if (meas_start)
            begin
              mode_q <= M_MEAS;
              id_q <= 1'b0;
            end
            else if (exec_q && !gc_q)
            begin
              id_q <= (cmd_q == `CMD_IDENT);
              if (cmd_q == `CMD_SLEEP)
              begin
                mode_q <= M_SLEEP;
              end
            end
          end
          M_MEAS:
          begin
            if (exec_q && !gc_q)
            begin
              if (cmd_q == `CMD_STOP)
              begin
                mode_q <= M_STOPPING;
                tmr_q <= STOP_CYC - 1;
              end
              else
              begin
                // Mode left untouched so the running measurement continues
                ign_q <= 1'b1;
              end
            end
          end
          M_SLEEP:
          begin
            if (wake_q)
            begin
              mode_q <= M_WAKING;
              tmr_q <= WAKE_CYC - 1;
            end
          end
          M_STOPPING, M_WAKING:
          begin
            if (tmr_q == 32'h0)
            begin
              mode_q <= M_IDLE;
            end
            else
            begin
              tmr_q <= tmr_q - 32'h1;
            end
          end
          default: mode_q <= M_IDLE;
        endcase
      end
    end
  end

  // Outputs from flops; the data pin only ever pulls low
  assign mode = mode_q;
  assign soft_reset = srst_q;
  assign cmd_ignored = ign_q;
  assign link.d_sda_o = 1'b0;
  assign link.d_sda_oe = sda_oe_q;
endmodule
`default_nettype wire

// ### include/sensor_consts.svh
// Constants shared by the flow sensor link ends
`ifndef SENSOR_CONSTS_SVH
`define SENSOR_CONSTS_SVH
`define CMD_SLEEP 16'h3677
`define CMD_IDENT 16'he102
`define CMD_STOP 16'h3ff9
`define GC_ADDR 8'h00
`define GC_RESET 8'h06
`define CRC_POLY 8'h31
`define CRC_INIT 8'hff
`define CRC_XOR 8'h00
`define FLOW_SCALE 16'h00aa
`define FLOW_OFFSET 16'ha000
`define TEMP_SCALE 16'h00c8
`define TEMP_OFFSET 16'h0000
`define CLK_MHZ 200
`define WAKE_TIME_US 16000
`define STOP_TIME_NS 500000
`define WAKE_CYC (`WAKE_TIME_US * `CLK_MHZ)
`define STOP_MAX_CYC ((`STOP_TIME_NS * `CLK_MHZ) / 1000)
`define STOP_MIN_CYC ((`STOP_TIME_NS * `CLK_MHZ + 999) / 1000)
`endif

// ### include/sensor_pkg.sv
// Types and checksum shared by both link ends
`include "sensor_consts.svh"
package sensor_pkg;
  typedef enum logic [2:0] {M_IDLE, M_MEAS, M_STOPPING, M_SLEEP, M_WAKING} dev_mode_t;
  typedef enum logic [2:0] {P_OFF, P_ADDR, P_WR, P_RD, P_AACK, P_MACK} slv_ph_t;
  typedef enum logic [2:0] {H_IDLE, H_START, H_TX, H_RXACK, H_RX, H_TXACK, H_STOP, H_GAP} host_st_t;
  typedef enum logic [1:0] {OP_CMD, OP_READ, OP_WAKE} host_op_t;

  // Checksum over one data word, msb first
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = `CRC_INIT;
    for (int i = 15; i >= 0; i--)
    begin
      c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ `CRC_POLY) : {c[6:0], 1'b0};
    end
    return c ^ `CRC_XOR;
  endfunction
endpackage

// ### include/sensor_link_if.sv
// Two-wire link between the sensor end and the host end
`timescale 1ns/1ps
`default_nettype none
interface sensor_link_if;
  logic scl;
  logic sda;
  logic h_sda_o;
  logic h_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  // Open-drain wire: low whenever an enabled driver pulls low
  assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));
  modport dev(input scl, input sda, output d_sda_o, output d_sda_oe);
  modport host(output scl, input sda, output h_sda_o, output h_sda_oe);
endinterface
`default_nettype wire

// ### src/flow_host_end.sv
// Host end: link clock divider, command writes, reads, wake polling
`timescale 1ns/1ps
`default_nettype none
`include "sensor_consts.svh"
module flow_host_end
  import sensor_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h40,
  parameter logic [15:0] QTR_CYC = 16'h0008,
  parameter int unsigned STOP_WAIT_CYC = `STOP_MIN_CYC,
  parameter int unsigned POLL_GAP_CYC = 200
)
(
  input wire logic clk,
  input wire logic rst_n,
  sensor_link_if.host link,
  input wire logic op_valid,
  input wire host_op_t op,
  input wire logic [15:0] op_code,
  input wire logic [2:0] op_words,
  output logic op_ready,
  output logic [15:0] rd_word,
  output logic rd_valid,
  output logic crc_err,
  output logic nack,
  output logic [16:0] flow_net
);
  logic [1:0] sda_s_q;
  host_st_t st_q;
  host_op_t op_q;
  logic [15:0] code_q;
  logic [2:0] nw_q;
  logic [2:0] wc_q;
  logic [15:0] qc_q;
  logic [1:0] ph_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic [1:0] bidx_q;
  logic [1:0] rpos_q;
  logic [7:0] hi_q;
  logic [7:0] lo_q;
  logic ackd_q;
  logic more_q;
  logic [31:0] gap_q;
  logic scl_q;
  logic sda_oe_q;
  logic ready_q;
  logic [15:0] word_q;
  logic rv_q;
  logic ce_q;
  logic nk_q;
  logic [16:0] net_q;
  logic tick;
  logic [7:0] next_tx;
  // Offset held as a named constant so its sign bit can be replicated
  localparam logic [15:0] FLOW_OFS = `FLOW_OFFSET;

  // Data wire sampled through two flops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sda_s_q <= 2'h3;
    end
    else
    begin
      sda_s_q <= {sda_s_q[0], link.sda};
    end
  end

  // Quarter-period enable of the link clock
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      qc_q <= 16'h0;
    end
    else if (st_q == H_IDLE || st_q == H_GAP || tick)
    begin
      qc_q <= 16'h0;
    end
    else
    begin
      qc_q <= qc_q + 16'h1;
    end
  end
  assign tick = (qc_q == QTR_CYC - 16'h1);

  // Byte after the current one: write header, code high, code low
  always_comb
  begin
    case (bidx_q)
      2'h0: next_tx = code_q[15:8];
      default: next_tx = code_q[7:0];
    endcase
  end

  // Transfer sequencer; each bit spends four quarters
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= H_IDLE;
      op_q <= OP_CMD;
      code_q <= 16'h0;
      nw_q <= 3'h0;
      wc_q <= 3'h0;
      ph_q <= 2'h0;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      bidx_q <= 2'h0;
      rpos_q <= 2'h0;
      hi_q <= 8'h00;
      lo_q <= 8'h00;
      ackd_q <= 1'b0;
      more_q <= 1'b0;
      gap_q <= 32'h0;
      scl_q <= 1'b1;
      sda_oe_q <= 1'b0;
      ready_q <= 1'b1;
      word_q <= 16'h0;
      rv_q <= 1'b0;
      ce_q <= 1'b0;
      nk_q <= 1'b0;
      net_q <= 17'h0;
    end
    else
    begin
      rv_q <= 1'b0;
      ce_q <= 1'b0;
      nk_q <= 1'b0;
      case (st_q)
        H_IDLE:
        begin
          if (op_valid && ready_q)
          begin
            ready_q <= 1'b0;
            op_q <= op;
            code_q <= op_code;
            nw_q <= (op_words == 3'h0) ? 3'h1 : op_words;
            st_q <= H_START;
            ph_q <= 2'h0;
          end
        end
        H_GAP:
        begin
          if (gap_q != 32'h0)
          begin
            gap_q <= gap_q - 32'h1;
          end
          else if (op_q == OP_WAKE && !ackd_q)
          begin
            st_q <= H_START;
          end
          else
          begin
            st_q <= H_IDLE;
            ready_q <= 1'b1;
          end
        end
        default:
        begin
          if (tick)
          begin
            ph_q <= ph_q + 2'h1;
            case (st_q)
              H_START:
              begin
                case (ph_q)
                  2'h0: scl_q <= 1'b1;
                  2'h1: sda_oe_q <= 1'b1;
                  2'h3:
                  begin
                    scl_q <= 1'b0;
                    st_q <= H_TX;
                    bit_q <= 3'h0;
                    bidx_q <= 2'h0;
                    wc_q <= 3'h0;
                    rpos_q <= 2'h0;
                    sh_q <= {DEV_ADDR, op_q == OP_READ};
                  end
                  default: ;
                endcase
              end
              H_TX:
              begin
                case (ph_q)
                  2'h0: sda_oe_q <= ~sh_q[7];
                  2'h1: scl_q <= 1'b1;
                  2'h3:
                  begin
                    scl_q <= 1'b0;
                    sh_q <= {sh_q[6:0], 1'b0};
                    bit_q <= bit_q + 3'h1;
                    st_q <= (bit_q == 3'h7) ? H_RXACK : H_TX;
                  end
                  default: ;
                endcase
              end
              H_RXACK:
              begin
                case (ph_q)
                  2'h0: sda_oe_q <= 1'b0;
                  2'h1: scl_q <= 1'b1;
                  2'h2: ackd_q <= ~sda_s_q[1];
                  default:
                  begin
                    scl_q <= 1'b0;
                    bit_q <= 3'h0;
                    if (!ackd_q)
                    begin
                      nk_q <= (op_q != OP_WAKE);
                      st_q <= H_STOP;
                    end
                    else if (op_q == OP_READ)
                    begin
                      st_q <= H_RX;
                    end
                    else if (op_q == OP_CMD && bidx_q != 2'h2)
                    begin
                      sh_q <= next_tx;
                      bidx_q <= bidx_q + 2'h1;
                      st_q <= H_TX;
                    end
                    else
                    begin
                      st_q <= H_STOP;
                    end
                  end
                endcase
              end
              H_RX:
              begin
                case (ph_q)
                  2'h0: sda_oe_q <= 1'b0;
                  2'h1: scl_q <= 1'b1;
                  2'h2: sh_q <= {sh_q[6:0], sda_s_q[1]};
                  default:
                  begin
                    scl_q <= 1'b0;
                    bit_q <= bit_q + 3'h1;
                    if (bit_q == 3'h7)
                    begin
                      st_q <= H_TXACK;
                      more_q <= !(rpos_q == 2'h2 && wc_q == nw_q - 3'h1);
                      rpos_q <= (rpos_q == 2'h2) ? 2'h0 : rpos_q + 2'h1;
                      if (rpos_q == 2'h0)
                      begin
                        hi_q <= sh_q;
                      end
                      else if (rpos_q == 2'h1)
                      begin
                        lo_q <= sh_q;
                      end
                      else
                      begin
                        // Checksum covers only the two bytes just before it
                        ce_q <= (crc8({hi_q, lo_q}) != sh_q);
                        word_q <= {hi_q, lo_q};
                        rv_q <= 1'b1;
                        net_q <= {hi_q[7], hi_q, lo_q} - {FLOW_OFS[15], FLOW_OFS};
                        wc_q <= wc_q + 3'h1;
                      end
                    end
                  end
                endcase
              end
              H_TXACK:
              begin
                case (ph_q)
                  2'h0: sda_oe_q <= more_q;
                  2'h1: scl_q <= 1'b1;
                  2'h3:
                  begin
                    scl_q <= 1'b0;
                    bit_q <= 3'h0;
                    st_q <= more_q ? H_RX : H_STOP;
                  end
                  default: ;
                endcase
              end
              default:
              begin
                case (ph_q)
                  2'h0: sda_oe_q <= 1'b1;
                  2'h1: scl_q <= 1'b1;
                  2'h2: sda_oe_q <= 1'b0;
                  default:
                  begin
                    st_q <= H_GAP;
                    if (op_q == OP_CMD && code_q == `CMD_STOP)
                    begin
                      gap_q <= STOP_WAIT_CYC - 1;
                    end
                    else if (op_q == OP_WAKE && !ackd_q)
                    begin
                      gap_q <= POLL_GAP_CYC - 1;
                    end
                    else
                    begin
                      gap_q <= 32'h0;
                    end
                  end
                endcase
              end
            endcase
          end
        end
      endcase
    end
  end

  // Outputs straight from flops, except the data level, which is tied low
  assign op_ready = ready_q;
  assign rd_word = word_q;
  assign rd_valid = rv_q;
  assign crc_err = ce_q;
  assign nack = nk_q;
  assign flow_net = net_q;
  assign link.scl = scl_q;
  assign link.h_sda_o = 1'b0;
  assign link.h_sda_oe = sda_oe_q;
endmodule
`default_nettype wire

// ### test/sensor_link_chk.sv
// Wire-level checks on the two-wire link between both ends
`timescale 1ns/1ps
`default_nettype none
module sensor_link_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic h_sda_o,
  input wire logic h_sda_oe,
  input wire logic d_sda_o,
  input wire logic d_sda_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Open-drain ends may only pull low, never drive high
  a_dev_pull_low:
    assert property (d_sda_oe |-> !d_sda_o) else $error("sensor drives sda high");
  a_host_pull_low:
    assert property (h_sda_oe |-> !h_sda_o) else $error("host drives sda high");
  // Sensor data may only move while the link clock is low
  a_dev_scl_low:
    assert property ($changed(d_sda_oe) |-> !scl) else $error("sensor sda moved in scl high");
  // An acknowledge followed by a byte of zeros is the longest the sensor may hold sda
  a_dev_release:
    assert property ($rose(d_sda_oe) |-> ##[1:300] !d_sda_oe) else $error("sensor holds sda");
  a_scl_high_len:
    assert property ($rose(scl) |=> scl [*8]) else $error("scl high too short");
  a_scl_low_len:
    assert property ($fell(scl) |=> !scl [*8]) else $error("scl low too short");
  // Start and stop edges only while the sensor has let go of sda
  a_host_frame_free:
    assert property ($changed(h_sda_oe) && scl |-> !d_sda_oe)
      else $error("start or stop under sensor");
  a_idle_after_rst:
    assert property ($rose(rst_n) |-> scl && !h_sda_oe && !d_sda_oe) else $error("link busy");
endmodule
`default_nettype wire

// ### test/tb.sv
// Self-checking bench: sensor end and host end facing each other
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sensor_pkg::*;
  localparam logic [31:0] PID = 32'h5a6b7c13; // Arbitrary value; low digits 1x mark final
  localparam logic [63:0] SER = 64'h000000007d3ab741; // Decimal 2101000001
  localparam logic [95:0] ID = {PID, SER};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic meas_start = 1'b0;
  logic [15:0] flow_raw = 16'h0000;
  logic [15:0] temp_raw = 16'h0000;
  logic op_valid = 1'b0;
  host_op_t op = OP_CMD;
  logic [15:0] op_code = 16'h0000;
  logic [2:0] op_words = 3'h0;
  dev_mode_t mode;
  logic soft_reset, cmd_ignored, op_ready, rd_valid, crc_err, nack;
  logic [15:0] rd_word;
  logic [16:0] flow_net;
  logic [32:0] exp_q[$];
  logic [31:0] rnd = 32'h00017b6e;
  int err_count = 0;
  int check_count = 0;
  int ign_n = 0;
  int nack_n = 0;
  int rst_n_seen = 0;
  sensor_link_if link();
  flow_sensor_end #(.PRODUCT_ID(PID), .SERIAL_NO(SER), .WAKE_CYC(400), .STOP_CYC(400))
    flow_sensor_end_i (.clk(clk), .rst_n(rst_n), .link(link), .meas_start(meas_start),
    .flow_raw(flow_raw), .temp_raw(temp_raw), .mode(mode), .soft_reset(soft_reset),
    .cmd_ignored(cmd_ignored));
  flow_host_end #(.STOP_WAIT_CYC(400)) flow_host_end_i (.clk(clk), .rst_n(rst_n), .link(link),
    .op_valid(op_valid), .op(op), .op_code(op_code), .op_words(op_words), .op_ready(op_ready),
    .rd_word(rd_word), .rd_valid(rd_valid), .crc_err(crc_err), .nack(nack), .flow_net(flow_net));
  sensor_link_chk sensor_link_chk_i (.clk(clk), .rst_n(rst_n), .scl(link.scl), .sda(link.sda),
    .h_sda_o(link.h_sda_o), .h_sda_oe(link.h_sda_oe), .d_sda_o(link.d_sda_o),
    .d_sda_oe(link.d_sda_oe));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("Checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Note a word and its offset-corrected value; offset -24576 means adding 0x6000
  task automatic expect_word(input logic [15:0] w);
    exp_q.push_back({{w[15], w} + 17'h06000, w});
  endtask

  // One host op; the wait is bounded so a hung link ends the run
  task automatic op_run(input host_op_t o, input logic [15:0] c, input logic [2:0] w);
    int n;
    n = 0;
    @(negedge clk);
    op_valid = 1'b1;
    op = o;
    op_code = c;
    op_words = w;
    @(negedge clk);
    op_valid = 1'b0;
    while (op_ready !== 1'b1 && n < 20000)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 20000)
    begin
      err_count++;
      final_report();
    end
  endtask

  // Each word that arrives is matched against the oldest note; sampled off the launch edge
  always @(negedge clk)
  begin
    if (rd_valid === 1'b1)
    begin
      check({flow_net, rd_word}, exp_q.size() > 0 ? exp_q.pop_front() : 33'h1ffffffff);
      check(crc_err, 1'b0);
    end
    ign_n += (cmd_ignored === 1'b1);
    nack_n += (nack === 1'b1);
    rst_n_seen += (soft_reset === 1'b1);
  end

  initial
  begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    // Known checksum of a fixed word pins down the shared algorithm
    check(crc8(16'hbeef), 8'h92);
    // Identity from idle: product then serial, each word checksummed
    op_run(OP_CMD, 16'he102, 3'h0);
    for (int i = 0; i < 6; i++)
      expect_word(ID[95 - 16 * i -: 16]);
    op_run(OP_READ, 16'h0000, 3'h6);
    @(negedge clk) meas_start = 1'b1;
    @(negedge clk) meas_start = 1'b0;
    check(mode, M_MEAS);
    // Signed readings, the most negative one first
    for (int i = 0; i < 3; i++)
    begin
      rnd = lfsr(rnd);
      flow_raw = (i == 0) ? 16'h8000 : rnd[15:0];
      temp_raw = rnd[31:16];
      expect_word(flow_raw);
      expect_word(temp_raw);
      op_run(OP_READ, 16'h0000, 3'h2);
    end
    // Sleep and identifier refused while measuring
    op_run(OP_CMD, 16'h3677, 3'h0);
    op_run(OP_CMD, 16'he102, 3'h0);
    check(ign_n, 2);
    check(mode, M_MEAS);
    op_run(OP_CMD, 16'h3ff9, 3'h0);
    check(mode, M_IDLE);
    op_run(OP_CMD, 16'h3677, 3'h0);
    check(mode, M_SLEEP);
    // A read header neither wakes nor is acknowledged
    op_run(OP_READ, 16'h0000, 3'h1);
    check(nack_n, 1);
    check(mode, M_SLEEP);
    op_run(OP_WAKE, 16'h0000, 3'h0);
    check(mode, M_IDLE);
    op_run(OP_CMD, 16'he102, 3'h0);
    expect_word(PID[31:16]);
    expect_word(PID[15:0]);
    op_run(OP_READ, 16'h0000, 3'h2);
    check(exp_q.size(), 0);
    check(rst_n_seen, 0);
    final_report();
  end
endmodule
`default_nettype wire
